// ==== hw/sdp_defines.vh ====
`ifndef SDP_DEFINES_VH
`define SDP_DEFINES_VH

// Wide variant: 36-bit words, 18-bit burst address
`define SDP_ADDR_W 18
`define SDP_DATA_W 36
`define SDP_LANES 4
`define SDP_LANE_W 9
`define SDP_DEPTH 262144

// Read pipeline: four slots, output taken from the last one
`define SDP_SLOTS 4
`define SDP_SLOT_LAST 3
// Slot that receives the first burst word, by latency mode
`define SDP_SLOT_W0_PLL 2'h1
`define SDP_SLOT_W0_NOPLL 2'h2

// Cycles after reset before clock edges are trusted
`define SDP_PRIME_CNT 2'h3
`define SDP_PRIME_RST 2'h0

// Reset values
`define SDP_DATA_RST 36'h0
`define SDP_LANE_RST 4'hF
`define SDP_ADDR_RST 18'h0

`endif

// ==== hw/sdp_word_array.v ====
`timescale 1ns/10ps
`include "sdp_defines.vh"

module sdp_word_array (
    input wire mclk,
    input wire wrEn,
    input wire [`SDP_ADDR_W-1:0] wrAddr,
    input wire [`SDP_DATA_W-1:0] wrData,
    input wire [`SDP_LANES-1:0] wrLaneSel_n,
    input wire [`SDP_ADDR_W-1:0] rdAddr,
    output wire [`SDP_DATA_W-1:0] rdData
);

    reg [`SDP_DATA_W-1:0] mem [0:`SDP_DEPTH-1];
    wire [`SDP_DATA_W-1:0] oldWord;
    wire [`SDP_DATA_W-1:0] merged;

    assign oldWord = mem[wrAddr];
    assign rdData = mem[rdAddr];

    // ----------------------------------------
    // Byte lane merge
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < `SDP_LANES; g = g + 1) begin : laneMerge
            assign merged[g*`SDP_LANE_W +: `SDP_LANE_W] = wrLaneSel_n[g] ?
                oldWord[g*`SDP_LANE_W +: `SDP_LANE_W] : // RULE5
                wrData[g*`SDP_LANE_W +: `SDP_LANE_W]; // RULE4
        end
    endgenerate

    // Array contents are not reset; a real core powers up undefined
    always @(posedge mclk) begin
        if (wrEn) begin
            mem[wrAddr] <= merged;
        end
    end

endmodule // sdp_word_array

// ==== hw/sdp_sram_ports.v ====
// Functional notes
// RULE1: Write data words are captured on rising edges of both input clocks.
// RULE2: Write select is active low, sampled on true clock rise; low starts write.
// RULE3: Write data is ignored while the write port is deselected.
// RULE4: Byte write selects, active low, sampled on both edges, gate each lane.
// RULE5: Lanes not selected keep their old contents.
// RULE6: Read address on true clock rise, write address on complementary rise.
// RULE7: Address is 18 bits wide here; one address holds a two-word burst.
// RULE8: Two internal arrays of 256K words; burst word n goes to array n.
// RULE9: Address is ignored on edges whose port is deselected.
// RULE10: Read data leaves on output clock edges, or input clocks in single mode.
// RULE11: Read data outputs float when no read is in progress.
// RULE12: Read select is active low, sampled on true clock rise; low starts read.
// RULE13: On deselect, pending read finishes, then drivers float after next edge.
// RULE14: Each read returns two words of the addressed burst in order.
// RULE15: All accesses begin on a rising edge of the true input clock.
// RULE16: PLL disable low selects the one-cycle latency compatible mode.
// RULE17: Free-running echo clocks follow the output clock, or input clock.
// RULE18: Read latency is 1.5 cycles with PLL, one cycle with PLL off.
// RULE19: Host supplies write words on true then complementary edge of the write.
`timescale 1ns/10ps
`include "sdp_defines.vh"

module sdp_sram_ports (
    input wire mclk,
    input wire rst_b,
    input wire kClk,
    input wire kClkB,
    input wire cClk,
    input wire cClkB,
    input wire singleClkMode,
    input wire pll_disable_n,
    input wire write_port_sel_n,
    input wire read_port_sel_n,
    input wire [`SDP_LANES-1:0] byte_lane_write_sel_n,
    input wire [`SDP_ADDR_W-1:0] addr,
    input wire [`SDP_DATA_W-1:0] wrData,
    output reg [`SDP_DATA_W-1:0] rdData,
    output reg rdDataOe,
    output reg echo_clk,
    output reg echo_clkB
);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    localparam PW = 8 + `SDP_LANES + `SDP_ADDR_W + `SDP_DATA_W;

    wire [PW-1:0] pinRaw;
    reg [PW-1:0] pinMeta;
    reg [PW-1:0] pinSync;
    reg [3:0] clkDly;

    assign pinRaw = {kClk, kClkB, cClk, cClkB, singleClkMode, pll_disable_n, write_port_sel_n,
                     read_port_sel_n, byte_lane_write_sel_n, addr, wrData};

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pinMeta <= {PW{1'b0}};
            pinSync <= {PW{1'b0}};
            clkDly <= 4'h0;
        end else begin
            pinMeta <= pinRaw;
            pinSync <= pinMeta;
            clkDly <= pinSync[PW-1 -: 4];
        end
    end

    wire kS = pinSync[PW-1];
    wire kbS = pinSync[PW-2];
    wire cS = pinSync[PW-3];
    wire cbS = pinSync[PW-4];
    wire singleS = pinSync[PW-5];
    wire pllOn = pinSync[PW-6];
    wire wrSelS_n = pinSync[PW-7];
    wire rdSelS_n = pinSync[PW-8];
    wire [`SDP_LANES-1:0] laneS_n = pinSync[`SDP_ADDR_W+`SDP_DATA_W +: `SDP_LANES];
    wire [`SDP_ADDR_W-1:0] addrS = pinSync[`SDP_DATA_W +: `SDP_ADDR_W];
    wire [`SDP_DATA_W-1:0] dataS = pinSync[`SDP_DATA_W-1:0];

    // ----------------------------------------
    // Clock edge detection
    // ----------------------------------------
    // Stages leave reset at zero while an idle clock pin may sit high;
    // edges are held off until both stages and the delay tap carry pin data
    reg [1:0] primeCnt;
    wire primed = (primeCnt == `SDP_PRIME_CNT);

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            primeCnt <= `SDP_PRIME_RST;
        end else if (!primed) begin
            primeCnt <= primeCnt + 2'h1;
        end
    end

    // All pins share the same two-stage delay, so edges and data stay aligned
    wire kRise = primed & kS & ~clkDly[3];
    wire kbRise = primed & kbS & ~clkDly[2];
    wire cRise = primed & cS & ~clkDly[1];
    wire cbRise = primed & cbS & ~clkDly[0];

    // ----------------------------------------
    // Output clock selection
    // ----------------------------------------
    wire outRise = singleS ? kRise : cRise; // RULE10
    wire outRiseB = singleS ? kbRise : cbRise; // RULE10
    wire outEvt = outRise | outRiseB;

    // ----------------------------------------
    // Write port
    // ----------------------------------------
    reg wrActive;
    reg [`SDP_DATA_W-1:0] wrWord0;
    reg [`SDP_LANES-1:0] wrLane0_n;

    wire wrStart = kRise & ~wrSelS_n; // RULE2 RULE15
    wire wrCommit = kbRise & wrActive;

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wrActive <= 1'b0;
            wrWord0 <= `SDP_DATA_RST;
            wrLane0_n <= `SDP_LANE_RST;
        end else begin
            if (wrStart) begin
                wrActive <= 1'b1;
                wrWord0 <= dataS; // RULE1 RULE19
                wrLane0_n <= laneS_n; // RULE4
            end else if (wrCommit) begin
                wrActive <= 1'b0;
            end
        end
    end

    // Data, lanes and address are only looked at inside an active write
    wire wrEn = wrCommit; // RULE3 RULE9

    // ----------------------------------------
    // Arrays: word 0 and word 1 of every burst
    // ----------------------------------------
    wire [`SDP_DATA_W-1:0] arrRd0;
    wire [`SDP_DATA_W-1:0] arrRd1;

    sdp_word_array arrWord0 ( // RULE8
        .mclk(mclk),
        .wrEn(wrEn),
        .wrAddr(addrS), // RULE6 RULE7
        .wrData(wrWord0),
        .wrLaneSel_n(wrLane0_n),
        .rdAddr(addrS),
        .rdData(arrRd0)
    );

    sdp_word_array arrWord1 ( // RULE8
        .mclk(mclk),
        .wrEn(wrEn),
        .wrAddr(addrS),
        .wrData(dataS), // RULE1 RULE19
        .wrLaneSel_n(laneS_n), // RULE4
        .rdAddr(addrS),
        .rdData(arrRd1)
    );

    // ----------------------------------------
    // Read port: output slot line
    // ----------------------------------------
    // Each output clock edge moves the line by one; a read drops its two
    // words at positions chosen so word 0 leaves after the right latency.
    reg [`SDP_DATA_W-1:0] slot [0:`SDP_SLOTS-1];
    reg [`SDP_SLOTS-1:0] slotV;

    wire rdTake = kRise & ~rdSelS_n; // RULE12 RULE15 RULE9
    wire [1:0] w0Base = pllOn ? `SDP_SLOT_W0_PLL : `SDP_SLOT_W0_NOPLL; // RULE16 RULE18
    // A shift in the take cycle never moves words landed at that edge
    wire [1:0] w0Idx = w0Base;
    wire [1:0] w1Idx = w0Idx - 2'h1;

    integer i;

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            for (i = 0; i < `SDP_SLOTS; i = i + 1) begin
                slot[i] <= `SDP_DATA_RST;
            end
            slotV <= {`SDP_SLOTS{1'b0}};
            rdData <= `SDP_DATA_RST;
            rdDataOe <= 1'b0;
        end else begin
            if (outEvt) begin
                for (i = 1; i < `SDP_SLOTS; i = i + 1) begin
                    slot[i] <= slot[i-1];
                end
                slot[0] <= `SDP_DATA_RST;
                slotV <= {slotV[`SDP_SLOTS-2:0], 1'b0};
                rdData <= slot[`SDP_SLOT_LAST]; // RULE10
                rdDataOe <= slotV[`SDP_SLOT_LAST]; // RULE11 RULE13
            end
            if (rdTake) begin
                slot[w0Idx] <= arrRd0; // RULE14
                slot[w1Idx] <= arrRd1; // RULE14
                slotV[w0Idx] <= 1'b1;
                slotV[w1Idx] <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Echo clocks
    // ----------------------------------------
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            echo_clk <= 1'b0;
            echo_clkB <= 1'b0;
        end else begin
            echo_clk <= singleS ? kS : cS; // RULE17
            echo_clkB <= singleS ? kbS : cbS; // RULE17
        end
    end

endmodule // sdp_sram_ports

// ==== verification/sdp_port_monitor.sv ====
`timescale 1ns/10ps
`include "sdp_defines.vh"
module sdp_port_monitor (
    input wire mclk,
    input wire rst_b,
    input wire kClk,
    input wire cClk,
    input wire cClkB,
    input wire singleClkMode,
    input wire pll_disable_n,
    input wire read_port_sel_n,
    input wire [`SDP_DATA_W-1:0] rdData,
    input wire rdDataOe,
    input wire echo_clk,
    input wire echo_clkB
);
    reg [2:0] age;
    reg [2:0] rdCnt;
    reg modeD, kD, cD, cbD;
    // Output edges since the last read take; saturates once the burst is over
    wire anyRise = (cClk & ~cD) | (cClkB & ~cbD);
    wire aged = age == 3'h7;
    wire ok = aged & ~singleClkMode;
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            age <= 3'h0;
            rdCnt <= 3'h7;
            {modeD, kD, cD, cbD} <= 4'h0;
        end else begin
            {modeD, kD, cD, cbD} <= {singleClkMode, kClk, cClk, cClkB};
            age <= (modeD != singleClkMode) ? 3'h0 : age + {2'h0, !aged};
            if (kClk && !kD && !read_port_sel_n)
                rdCnt <= 3'h0;
            else if (anyRise && rdCnt != 3'h7)
                rdCnt <= rdCnt + 3'h1;
        end
    end
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    sequence burstOut;
        rdDataOe [*6];
    endsequence
    a_echo_true: assert property (ok |-> echo_clk == $past(cClk, 3))
        else $error("echo_clk off");
    a_echo_comp: assert property (ok |-> echo_clkB == $past(cClkB, 3))
        else $error("echo_clkB off");
    a_echo_single: assert property (aged && singleClkMode |-> echo_clk == $past(kClk, 3))
        else $error("single mode echo off");
    a_data_on_edge: assert property (ok && $changed(rdData) |-> $past(anyRise, 3))
        else $error("rdData moved off edge");
    a_oe_on_edge: assert property (ok && $changed(rdDataOe) |-> $past(anyRise, 3))
        else $error("rdDataOe moved off edge");
    a_oe_idle_low: assert property (ok && rdCnt == 3'h7 |-> !rdDataOe)
        else $error("outputs driven when idle");
    a_lat_pll: assert property (ok && anyRise && rdCnt == 3'h2 && pll_disable_n |-> ##3 burstOut)
        else $error("late burst with pll");
    a_lat_nopll: assert property (ok && anyRise && rdCnt == 3'h1 && !pll_disable_n |-> ##3 burstOut)
        else $error("late burst without pll");
endmodule // sdp_port_monitor

bind sdp_sram_ports sdp_port_monitor i_mon (.mclk, .rst_b, .kClk, .cClk, .cClkB, .singleClkMode, .pll_disable_n,
    .read_port_sel_n, .rdData, .rdDataOe, .echo_clk, .echo_clkB);

// ==== verification/sdp_host_model.sv ====
`timescale 1ns/10ps
`include "sdp_defines.vh"
module sdp_host_model (
    input wire mclk,
    output reg kClk,
    output wire kClkB,
    output wire cClk,
    output wire cClkB,
    output reg write_port_sel_n,
    output reg read_port_sel_n,
    output reg [`SDP_LANES-1:0] byte_lane_write_sel_n,
    output reg [`SDP_ADDR_W-1:0] addr,
    output reg [`SDP_DATA_W-1:0] wrData
);
    reg [2:0] ph = 3'h4;
    assign kClkB = ~kClk;
    // Single clock mode parks both output clocks high
    reg cTied = 1'b0;
    assign cClk = cTied | kClk;
    assign cClkB = cTied | kClkB;
    initial begin
        kClk = 1'b0;
        {write_port_sel_n, read_port_sel_n, byte_lane_write_sel_n, addr, wrData} = {6'h3F, 54'h0};
    end
    always @(posedge mclk) begin
        #1;
        ph = ph + 3'h1;
        kClk = ~ph[2];
    end
    // Inputs move mid half-period so they stay steady around each K edge
    task automatic cyc(input logic wr_n, input logic rd_n, input logic [`SDP_ADDR_W-1:0] ra,
        input logic [`SDP_ADDR_W-1:0] wa, input logic [`SDP_DATA_W-1:0] w0, input logic [`SDP_DATA_W-1:0] w1,
        input logic [7:0] lanes);
        @(posedge mclk);
        while (ph != 3'h5) @(posedge mclk);
        #1;
        {write_port_sel_n, read_port_sel_n, byte_lane_write_sel_n, addr, wrData} = {wr_n, rd_n, lanes[3:0], ra, w0};
        while (ph != 3'h1) @(posedge mclk);
        #1;
        {write_port_sel_n, read_port_sel_n, byte_lane_write_sel_n, addr, wrData} = {2'h3, lanes[7:4], wa, w1};
    endtask
endmodule // sdp_host_model

// ==== verification/sdp_sram_ports_test.sv ====
`timescale 1ns/10ps
`include "sdp_defines.vh"
module sdp_sram_ports_test;
    reg mclk = 1'b0;
    reg rst_b = 1'b0;
    reg singleClkMode = 1'b0;
    reg pll_disable_n = 1'b1;
    wire kClk, kClkB, cClk, cClkB, write_port_sel_n, read_port_sel_n, rdDataOe, echo_clk, echo_clkB;
    wire [`SDP_LANES-1:0] byte_lane_write_sel_n;
    wire [`SDP_ADDR_W-1:0] addr;
    wire [`SDP_DATA_W-1:0] wrData, rdData;
    integer miscompares = 0;
    integer check_count = 0;
    localparam [35:0] D0 = 36'h123456789, D1 = 36'hFEDCBA987, D2 = 36'h0F0F0F0F0, D3 = 36'h5A5A5A5A5;
    localparam [35:0] LM = 36'h007FC01FF;
    localparam [17:0] A1 = 18'h00001, A2 = 18'h3FFFE;
    sdp_host_model i_host (.mclk, .kClk, .kClkB, .cClk, .cClkB, .write_port_sel_n, .read_port_sel_n,
        .byte_lane_write_sel_n, .addr, .wrData);
    sdp_sram_ports i_dut (.mclk, .rst_b, .kClk, .kClkB, .cClk, .cClkB, .singleClkMode, .pll_disable_n,
        .write_port_sel_n, .read_port_sel_n, .byte_lane_write_sel_n, .addr, .wrData, .rdData, .rdDataOe,
        .echo_clk, .echo_clkB);
    initial forever #10 mclk = ~mclk;
    task automatic cmp(input logic [`SDP_DATA_W-1:0] got, input logic [`SDP_DATA_W-1:0] exp);
        check_count = check_count + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_flag(input logic got, input logic exp);
        check_count = check_count + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("wrong value at %0t: flag got %b expected %b", $time, got, exp);
        end
    endtask
    // Read with junk on the deselected write side, then sample both words and the release
    task automatic rd_chk(input logic [`SDP_ADDR_W-1:0] a, input logic [`SDP_DATA_W-1:0] e0,
        input logic [`SDP_DATA_W-1:0] e1);
        i_host.cyc(1'b1, 1'b0, a, ~a, ~e0, e0, 8'h00);
        repeat (pll_disable_n ? 15 : 11) @(posedge mclk);
        #1;
        cmp(rdData, e0);
        cmp_flag(rdDataOe, 1'b1);
        repeat (4) @(posedge mclk);
        #1;
        cmp(rdData, e1);
        repeat (4) @(posedge mclk);
        #1;
        cmp_flag(rdDataOe, 1'b0);
    endtask
    task t_burst;
        i_host.cyc(1'b0, 1'b1, A2, A1, D0, D1, 8'h00);
        i_host.cyc(1'b0, 1'b1, A1, A2, D2, D3, 8'h00);
        rd_chk(A1, D0, D1);
        rd_chk(A2, D2, D3);
    endtask
    task t_lanes;
        i_host.cyc(1'b0, 1'b1, A2, A1, ~D0, ~D1, 8'h5A);
        i_host.cyc(1'b1, 1'b1, A1, A1, D2, D3, 8'h00);
        rd_chk(A1, D0 ^ LM, D1 ^ ~LM);
    endtask
    task t_modes;
        pll_disable_n = 1'b0;
        i_host.cyc(1'b1, 1'b1, A1, A1, D0, D1, 8'h00);
        rd_chk(A2, D2, D3);
        singleClkMode = 1'b1;
        i_host.cTied = 1'b1;
        i_host.cyc(1'b1, 1'b1, A1, A1, D0, D1, 8'h00);
        rd_chk(A2, D2, D3);
    endtask
    task wrap_up;
        if (miscompares == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        #100000;
        miscompares = miscompares + 1;
        wrap_up;
    end
    initial begin
        repeat (16) @(posedge mclk);
        #1;
        rst_b = 1'b1;
        t_burst;
        t_lanes;
        t_modes;
        wrap_up;
    end
endmodule // sdp_sram_ports_test
